/* design/cwt_config_top.sv */
// setup word holder, option outputs and transmitter mode control
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - the setup word is twelve bits wide and feeds oscillator, reset, watchdog and protect.
// - setup bits change at the load after reset and while programming is enabled, never in normal running.
// - bit 4 high enables the reset pin, low holds the internal reset inactive.
// - bit 2 high turns the watchdog on, low turns it off.
// - bit 3 alone decides whether program memory is protected.
// - bits 1 to 0 pick external RC, internal RC, crystal or low power crystal.
// - both crystal modes accept a driven clock on the oscillator input pin.
// - transmitter enable high turns on the transmitter and the reference clock.
// - transmitter enable low puts the transmitter and reference clock in standby.
// - the transmitter enable input carries a weak pull-down.
// - keying data low drops the amplifier output to its minimum.
// - the keying pin acts as the on and off control of the amplifier.
module cwt_config_top
    import cwt_pkg::*;
#(
    parameter int WORD_W = CWT_WORD_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WORD_W-1:0] setupWordIn,
    input wire logic progEnableIn,
    input wire logic txEnableIn,
    input wire logic askDataIn,
    input wire logic extResetPinN,
    input wire logic [CWT_ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [WORD_W-1:0] rdData,
    output logic setupReady,
    output logic extResetRequest,
    output logic watchdogEnable,
    output logic codeProtectOn,
    output cwt_osc_t oscSelect,
    output logic oscInClockAccept,
    output logic txEnableState,
    output logic refClockOutEnable,
    output logic txStandby,
    output logic paKeyOn,
    output logic txEnablePullDown
);
    cwt_state_t state;
    cwt_state_t next_state;
    logic [CWT_USED_BITS-1:0] setupWord;
    logic [CWT_USED_BITS-1:0] next_setupWord;
    logic [WORD_W-1:0] next_rdData;
    logic [3:0] pinSync;
    logic progSync;
    logic txSync;
    logic askSync;
    logic resetPinLow;
    cwt_setup_t setupDec;
    logic crystalDec;
    logic resetReqDec;
    logic hitSetup;
    logic hitStatus;
    logic progWrite;
    logic paOnNext;
    logic [WORD_W-1:0] setupRead;
    logic [WORD_W-1:0] statusRead;

    generate
        if (WORD_W != CWT_WORD_W)
        begin : g_bad_width
            $error("cwt_config_top: setup word must be twelve bits");
        end
    endgenerate

    // every pin passes two flip-flops before use
    cwt_sync2 #(
        .W(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn({progEnableIn, txEnableIn, askDataIn, ~extResetPinN}),
        .syncOut(pinSync)
    );

    assign progSync = pinSync[3];
    assign txSync = pinSync[2];
    assign askSync = pinSync[1];
    assign resetPinLow = pinSync[0];

    cwt_setup_decode u_decode (
        .setupBits(setupWord),
        .setup(setupDec),
        .crystalMode(crystalDec),
        .extResetRequest(resetReqDec),
        .extResetPinLow(resetPinLow)
    );

    // register decode
    assign hitSetup = (addr == CWT_ADDR_SETUP);
    assign hitStatus = (addr == CWT_ADDR_STATUS);
    assign progWrite = wrStrobe && hitSetup && progSync && (state == CWT_RUN);
    assign paOnNext = txSync & askSync;

    // widen a five-bit field to the bus word, upper bits zero
    function automatic logic [WORD_W-1:0] widen_field(
        input logic [CWT_USED_BITS-1:0] field
    );
        widen_field = {{(WORD_W - CWT_USED_BITS){1'b0}}, field};
    endfunction

    // setup reads zero above bit 4
    assign setupRead = widen_field(setupWord);
    assign statusRead = widen_field({(state == CWT_RUN), progSync, paOnNext, askSync,
        txSync});

    // read mux, unmapped addresses read zero
    assign next_rdData = !rdStrobe ? CWT_RDATA_RESET :
        hitSetup ? setupRead :
        hitStatus ? statusRead : CWT_RDATA_RESET;

    // loader: capture the array once, then only programming may change it
    always_comb
    begin
        next_state = state;
        next_setupWord = setupWord;
        unique case (state)
            CWT_LOAD:
            begin
                next_setupWord = setupWordIn[CWT_USED_BITS-1:0];
                next_state = CWT_RUN;
            end
            CWT_RUN:
            begin
                if (progWrite)
                begin
                    next_setupWord = wrData[CWT_USED_BITS-1:0];
                end
            end
        endcase
    end

    // state and stored setup
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= CWT_LOAD;
            setupWord <= CWT_SETUP_RESET;
            rdData <= CWT_RDATA_RESET;
        end
        else
        begin
            state <= next_state;
            setupWord <= next_setupWord;
            rdData <= next_rdData;
        end
    end

    // option outputs, registered from the decoded word
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            setupReady <= 1'b0;
            extResetRequest <= 1'b0;
            watchdogEnable <= 1'b0;
            codeProtectOn <= 1'b0;
            oscSelect <= CWT_OSC_LOW_POWER_CRYSTAL;
            oscInClockAccept <= 1'b0;
        end
        else
        begin
            setupReady <= (state == CWT_RUN);
            extResetRequest <= resetReqDec;
            watchdogEnable <= setupDec.watchdogEnableBit;
            codeProtectOn <= ~setupDec.codeProtectBit;
            oscSelect <= setupDec.oscSelectField;
            oscInClockAccept <= crystalDec;
        end
    end

    // transmitter mode control from the synchronised pins
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            txEnableState <= 1'b0;
            refClockOutEnable <= 1'b0;
            txStandby <= 1'b1;
            paKeyOn <= 1'b0;
            txEnablePullDown <= 1'b0;
        end
        else
        begin
            txEnableState <= txSync;
            refClockOutEnable <= txSync;
            txStandby <= ~txSync;
            paKeyOn <= paOnNext;
            txEnablePullDown <= 1'b1;
        end
    end

    // checks on the block's outputs and its stored setup word
    a_setup_width_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        (rdStrobe && hitSetup) |=> (rdData[CWT_USED_BITS-1:0] == $past(setupWord)))
        else $error("setup read does not show the stored word");

    a_setup_held_frozen: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state == CWT_RUN && !progSync) |=> (setupWord == $past(setupWord)))
        else $error("setup word changed outside programming");

    a_reset_pin_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!setupWord[CWT_BIT_EXT_RESET]) |=> !extResetRequest)
        else $error("reset request while reset pin disabled");

    a_reset_pin_follows: assert property (
        @(posedge clk_sys) disable iff (rst)
        (setupWord[CWT_BIT_EXT_RESET] && resetPinLow) |=> extResetRequest)
        else $error("enabled reset pin ignored");

    a_watchdog_bit_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        ##1 (watchdogEnable == $past(setupWord[CWT_BIT_WATCHDOG])))
        else $error("watchdog enable does not follow bit 2");

    a_code_protect_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        !rst |=> (codeProtectOn == !$past(setupWord[CWT_BIT_CODE_PROT])))
        else $error("code protection does not follow bit 3");

    a_osc_select_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        (setupWord[1:0] == 2'h3) |=> (oscSelect == CWT_OSC_EXTERNAL_RC))
        else $error("oscillator field 11 not decoded as external RC");

    a_crystal_clock_in: assert property (
        @(posedge clk_sys) disable iff (rst)
        !rst |=> (oscInClockAccept == !$past(setupWord[1])))
        else $error("crystal modes must accept a driven clock");

    a_tx_enable_on: assert property (
        @(posedge clk_sys) disable iff (rst)
        txSync |=> (txEnableState && refClockOutEnable && !txStandby))
        else $error("transmitter not enabled while enable is high");

    a_tx_standby_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!txSync [*2]) |=> (txStandby && !refClockOutEnable && !paKeyOn))
        else $error("transmitter not in standby while enable is low");

    a_pull_down_on: assert property (
        @(posedge clk_sys) disable iff (rst)
        !rst |=> txEnablePullDown)
        else $error("enable pull-down not active");

    a_ask_zero_min: assert property (
        @(posedge clk_sys) disable iff (rst)
        !askSync |=> !paKeyOn)
        else $error("amplifier on while keying data is low");

    a_ask_key_on: assert property (
        @(posedge clk_sys) disable iff (rst)
        (txSync && askSync) |=> paKeyOn)
        else $error("amplifier off while keyed and enabled");

    a_upper_bits_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        rdStrobe |=> (rdData[WORD_W-1:CWT_USED_BITS] == '0))
        else $error("setup bits 11 to 5 read nonzero");

    a_osc_internal_rc: assert property (
        @(posedge clk_sys) disable iff (rst)
        (setupWord[1:0] == CWT_OSC_INTERNAL_RC) |=> (oscSelect == CWT_OSC_INTERNAL_RC))
        else $error("oscillator field 10 not decoded as internal RC");

    a_osc_crystal_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        (setupWord[1:0] == CWT_OSC_CRYSTAL_RESONATOR)
            |=> (oscSelect == CWT_OSC_CRYSTAL_RESONATOR))
        else $error("oscillator field 01 not decoded as crystal");

    a_osc_low_power: assert property (
        @(posedge clk_sys) disable iff (rst)
        (setupWord[1:0] == CWT_OSC_LOW_POWER_CRYSTAL)
            |=> (oscSelect == CWT_OSC_LOW_POWER_CRYSTAL))
        else $error("oscillator field 00 not decoded as low power crystal");

    a_read_idle_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        !rdStrobe |=> (rdData == '0))
        else $error("read data not zero outside a read");

    a_load_takes_word: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!rst && state == CWT_LOAD) |=> (setupWord == $past(setupWordIn[CWT_USED_BITS-1:0])))
        else $error("loader did not take the low setup bits");

    a_prog_write_lands: assert property (
        @(posedge clk_sys) disable iff (rst)
        progWrite |=> (setupWord == $past(wrData[CWT_USED_BITS-1:0])))
        else $error("programming write not stored");

    a_ready_after_load: assert property (
        @(posedge clk_sys) disable iff (rst)
        (!rst && state == CWT_RUN) |=> setupReady)
        else $error("ready flag missing after load");
endmodule
`default_nettype wire

/* include/cwt_pkg.sv */
// shared constants and types for the setup word and transmitter enable block
`default_nettype none
package cwt_pkg;
    // width of the nonvolatile setup word and of the register port
    localparam int CWT_WORD_W = 12;
    localparam int CWT_ADDR_W = 12;
    // register offsets
    localparam logic [11:0] CWT_ADDR_SETUP = 12'hFFF;
    localparam logic [11:0] CWT_ADDR_STATUS = 12'h001;
    // setup word field positions
    localparam int CWT_BIT_EXT_RESET = 4;
    localparam int CWT_BIT_CODE_PROT = 3;
    localparam int CWT_BIT_WATCHDOG = 2;
    localparam int CWT_OSC_LSB = 0;
    localparam int CWT_USED_BITS = 5;
    // status register field positions
    localparam int CWT_ST_TX_ENABLE = 0;
    localparam int CWT_ST_ASK_DATA = 1;
    localparam int CWT_ST_PA_ON = 2;
    localparam int CWT_ST_PROG = 3;
    localparam int CWT_ST_READY = 4;
    // reset values
    localparam logic [4:0] CWT_SETUP_RESET = 5'h00;
    localparam logic [11:0] CWT_RDATA_RESET = 12'h000;
    // two flip-flops on every pin input
    localparam int CWT_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        CWT_OSC_LOW_POWER_CRYSTAL = 2'b00,
        CWT_OSC_CRYSTAL_RESONATOR = 2'b01,
        CWT_OSC_INTERNAL_RC = 2'b10,
        CWT_OSC_EXTERNAL_RC = 2'b11
    } cwt_osc_t;

    // field order matches bits 4 down to 0 of the setup word
    typedef struct packed {
        logic extResetPinEnable;
        logic codeProtectBit;
        logic watchdogEnableBit;
        cwt_osc_t oscSelectField;
    } cwt_setup_t;

    typedef enum logic {
        CWT_LOAD = 1'b0,
        CWT_RUN = 1'b1
    } cwt_state_t;
endpackage

`default_nettype wire

/* design/cwt_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cwt_sync2
    import cwt_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1;

    generate
        if (W < 1)
        begin : g_bad
            $error("cwt_sync2: width must be at least one");
        end
    endgenerate

    // first stage is read only by the second
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stage1 <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1 <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule
`default_nettype wire

/* design/cwt_setup_decode.sv */
// decodes the stored setup bits into named settings
`timescale 1ns/10ps
`default_nettype none
module cwt_setup_decode
    import cwt_pkg::*;
(
    input wire logic [CWT_USED_BITS-1:0] setupBits,
    output cwt_setup_t setup,
    output logic crystalMode,
    output logic extResetRequest,
    input wire logic extResetPinLow
);
    // field split, upper word bits never reach here
    assign setup = cwt_setup_t'(setupBits);
    // both crystal modes take a driven clock on the oscillator input
    assign crystalMode = (setup.oscSelectField == CWT_OSC_LOW_POWER_CRYSTAL)
        || (setup.oscSelectField == CWT_OSC_CRYSTAL_RESONATOR);
    // reset pin counts only when enabled, else held inactive
    assign extResetRequest = setup.extResetPinEnable & extResetPinLow;
endmodule
`default_nettype wire

/* sim/cwt_port_model.sv */
// controller port model driving transmitter enable and keying pins
`timescale 1ns/10ps
`default_nettype none
module cwt_port_model
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wantTx,
    input wire logic wantAsk,
    output logic txEnableIn,
    output logic askDataIn
);
    // port latches, low out of reset so the transmitter rests
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            txEnableIn <= 1'b0;
            askDataIn <= 1'b0;
        end
        else
        begin
            txEnableIn <= wantTx;
            askDataIn <= wantAsk;
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the setup word and transmitter block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cwt_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] setupWordIn, addr, wrData, rdData;
    logic progEnableIn, extResetPinN, wrStrobe, rdStrobe, wantTx, wantAsk;
    logic txEnableIn, askDataIn, setupReady, extResetRequest, watchdogEnable;
    logic codeProtectOn, oscInClockAccept, txEnableState, refClockOutEnable;
    logic txStandby, paKeyOn, txEnablePullDown;
    cwt_osc_t oscSelect;
    int failures = 0;
    int totalChecks = 0;
    // rows: word, then watchdog, protect, osc, clock-in accept
    logic [16:0] rows [4] = '{{12'hFE4, 5'b11001}, {12'h009, 5'b00011},
        {12'h016, 5'b11100}, {12'hA1F, 5'b10110}};

    cwt_config_top cwt_config_top_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .setupWordIn(setupWordIn),
        .progEnableIn(progEnableIn),
        .txEnableIn(txEnableIn),
        .askDataIn(askDataIn),
        .extResetPinN(extResetPinN),
        .addr(addr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .rdData(rdData),
        .setupReady(setupReady),
        .extResetRequest(extResetRequest),
        .watchdogEnable(watchdogEnable),
        .codeProtectOn(codeProtectOn),
        .oscSelect(oscSelect),
        .oscInClockAccept(oscInClockAccept),
        .txEnableState(txEnableState),
        .refClockOutEnable(refClockOutEnable),
        .txStandby(txStandby),
        .paKeyOn(paKeyOn),
        .txEnablePullDown(txEnablePullDown)
    );
    cwt_port_model cwt_port_model_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .wantTx(wantTx),
        .wantAsk(wantAsk),
        .txEnableIn(txEnableIn),
        .askDataIn(askDataIn)
    );

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    task automatic chkw(input logic [11:0] got, input logic [11:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkw({11'h000, got}, {11'h000, exp});
    endtask
    // wait n edges, then let the updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [11:0] d);
        @(posedge clk_sys);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [11:0] a, input logic [11:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        #1;
        chkw(rdData, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        failures++;
        $display("Error %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        setupWordIn = 12'hFEB;
        {progEnableIn, wrStrobe, rdStrobe, wantTx, wantAsk} = 5'h00;
        extResetPinN = 1'b1;
        addr = 12'h000;
        wrData = 12'h000;
        tick(4);
        chkb(txStandby, 1'b1);
        @(posedge clk_sys);
        rst <= 1'b0;
        extResetPinN <= 1'b0;
        tick(4);
        chkb(setupReady, 1'b1);
        chkw({10'h000, oscSelect}, 12'h003);
        chkb(codeProtectOn, 1'b0);
        chkb(extResetRequest, 1'b0);
        rdc(12'hFFF, 12'h00B);
        @(posedge clk_sys);
        progEnableIn <= 1'b1;
        tick(3);
        for (int i = 0; i < 4; i++)
        begin
            wr(12'hFFF, rows[i][16:5]);
            tick(3);
            chkb(watchdogEnable, rows[i][4]);
            chkb(codeProtectOn, rows[i][3]);
            chkw({10'h000, oscSelect}, {10'h000, rows[i][2:1]});
            chkb(oscInClockAccept, rows[i][0]);
            chkb(extResetRequest, rows[i][9]);
            rdc(12'hFFF, {7'h00, rows[i][9:5]});
        end
        // writes outside programming are ignored
        @(posedge clk_sys);
        progEnableIn <= 1'b0;
        extResetPinN <= 1'b1;
        tick(3);
        wr(12'hFFF, 12'h000);
        tick(3);
        chkb(watchdogEnable, 1'b1);
        chkb(extResetRequest, 1'b0);
        rdc(12'hFFF, 12'h01F);
        wr(12'h001, 12'hFFF);
        rdc(12'h123, 12'h000);
        tick(1);
        chkw(rdData, 12'h000);
        // transmitter on with keying high, then low, then off
        @(posedge clk_sys);
        wantTx <= 1'b1;
        wantAsk <= 1'b1;
        tick(5);
        chkb(txEnableState, 1'b1);
        chkb(refClockOutEnable, 1'b1);
        chkb(txStandby, 1'b0);
        chkb(paKeyOn, 1'b1);
        rdc(12'h001, 12'h017);
        @(posedge clk_sys);
        wantAsk <= 1'b0;
        tick(5);
        chkb(paKeyOn, 1'b0);
        @(posedge clk_sys);
        wantAsk <= 1'b1;
        wantTx <= 1'b0;
        tick(5);
        chkb(txStandby, 1'b1);
        chkb(refClockOutEnable, 1'b0);
        chkb(paKeyOn, 1'b0);
        chkb(txEnablePullDown, 1'b1);
        // mid-run reset reloads the setup word from the array
        @(posedge clk_sys);
        setupWordIn <= 12'h004;
        rst <= 1'b1;
        tick(2);
        chkb(setupReady, 1'b0);
        @(posedge clk_sys);
        rst <= 1'b0;
        tick(3);
        chkb(watchdogEnable, 1'b1);
        chkb(codeProtectOn, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
